// >>> pcr_consts.vh
// constants for the protection configuration register bank
`ifndef PCR_CONSTS_VH
`define PCR_CONSTS_VH

// register indices on the register port
`define PCR_IDX_CLD 2'h0
`define PCR_IDX_THR 2'h1
`define PCR_IDX_PTY 2'h2
`define PCR_IDX_STS 2'h3

// reset values
`define PCR_CLD_RST 8'h1b
`define PCR_THR_RST 8'h08
`define PCR_PTY_RST 8'h47
`define PCR_STS_RST 6'h3f

// current_limit_droop_config fields
`define PCR_DROOP_MSB 7
`define PCR_DROOP_LSB 5
`define PCR_TCE_BIT 4
`define PCR_CL_MSB 3
`define PCR_CL_LSB 0
`define PCR_CL_MAX 4'hb

// threshold_level_config fields
`define PCR_THR_IMPL_MASK 8'h1f
`define PCR_PGL_BIT 4
`define PCR_OVL_MSB 3
`define PCR_OVL_LSB 2
`define PCR_UVL_MSB 1
`define PCR_UVL_LSB 0

// protection_type_enable_config fields
`define PCR_TRE_BIT 7
`define PCR_PVE_BIT 6

// protection order in type and status registers, bits 5..0
`define PCR_P_TR 5
`define PCR_P_PV 0
`define PCR_STS_TP 7
`define PCR_STS_PG 6

// retry / re-enable hold-off
`define PCR_RETRY_MS 130
`define PCR_CLK_KHZ 40000
`define PCR_RETRY_CYCLES (`PCR_RETRY_MS * `PCR_CLK_KHZ)
`define PCR_TMR_W 23

`endif

// >>> pcr_pct_scale.v
// scales the output setpoint by a percentage, registered result
`timescale 1ns/1ps
module pcr_pct_scale #(
	parameter MV_W = 16
) (
	// clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// operands
	input wire [MV_W-1:0] setpoint_mv_i,
	input wire [7:0] pct_i,
	// result
	output reg [MV_W-1:0] level_mv_o
);

	wire [MV_W+7:0] prod;
	wire [MV_W+7:0] quot;

	assign prod = setpoint_mv_i * pct_i;
	assign quot = prod / {{MV_W{1'b0}}, 8'h64};

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			level_mv_o <= {MV_W{1'b0}};
		end else begin
			level_mv_o <= quot[MV_W-1:0];
		end
	end

endmodule // pcr_pct_scale

// >>> pcr_protection_config_regs.v
// protection configuration registers, threshold decode and restart policy
`timescale 1ns/1ps
`include "pcr_consts.vh"

// How it works
// - droop code maps to slope, 0 to 2.35
// - current limit code maps 37% to 140%
// - limit codes above Bh saturate to Bh
// - power-good low edge 95% or 90%
// - overvoltage code gives 110, 120, 130%
// - threshold register upper three bits read zero
// - levels follow present setpoint as percentages
// - per-protection latch types, tracking/phase enables
// - non-latching trip retries every 130ms
// - each restart requests a tracked ramp
// - latching trip turns output off, stays off
// - latched restart needs 130ms, clear or cycle
// - temperature compensation enable bit held
// - status bits read zero while active and armed
module pcr_protection_config_regs #(
	parameter MV_W = 16,
	parameter RETRY_CYCLES = `PCR_RETRY_CYCLES
) (
	// clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// register port from the serial front end
	input wire [1:0] reg_sel_i,
	input wire reg_wr_i,
	input wire [7:0] reg_wdata_i,
	output reg [7:0] reg_rdata_o,
	// converter conditions, active high, order tr ot oc uv ov pv
	input wire [5:0] fault_cond_i,
	input wire temp_warn_i,
	input wire power_good_warn_i,
	input wire turn_on_i,
	input wire [MV_W-1:0] setpoint_mv_i,
	// decoded settings
	output reg [7:0] droop_slope_o,
	output reg droop_code_reserved_o,
	output reg [7:0] current_limit_pct_o,
	output reg temp_comp_enable_o,
	output wire [MV_W-1:0] overvoltage_mv_o,
	output wire [MV_W-1:0] undervoltage_mv_o,
	output wire [MV_W-1:0] power_good_low_mv_o,
	// output control
	output reg output_enable_o,
	output reg ramp_request_o,
	output reg latched_off_o
);

	localparam S_OFF = 2'd0;
	localparam S_RUN = 2'd1;
	localparam S_RETRY = 2'd2;
	localparam S_LATCH = 2'd3;
	// hold-off counts from the trip edge, so reload one short
	localparam integer TMR_LOAD_INT = RETRY_CYCLES - 1;
	localparam [`PCR_TMR_W-1:0] TMR_LOAD = TMR_LOAD_INT[`PCR_TMR_W-1:0];

	reg [7:0] cld_reg;
	reg [7:0] thr_reg;
	reg [7:0] pty_reg;
	reg [5:0] sts_reg;
	reg [5:0] sts_next;
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [`PCR_TMR_W-1:0] tmr_reg;
	reg [`PCR_TMR_W-1:0] tmr_next;
	reg cycled_reg;
	reg cycled_next;
	reg [5:0] cause_reg;
	reg [5:0] cause_next;
	reg [7:0] ov_pct;
	reg [7:0] uv_pct;
	reg [7:0] pg_pct;
	reg [7:0] cl_tab;
	reg [7:0] slope_tab;
	reg slope_rsv;
	reg [7:0] rdata_next;
	wire [5:0] en_mask;
	wire [5:0] trip;
	wire any_trip;
	wire latch_trip;
	wire tmr_done;
	wire sts_clear_ok;
	wire [3:0] cl_wr;

	// tracking and phase faults may be masked off; others always armed
	assign en_mask = {pty_reg[`PCR_TRE_BIT], 4'hf,
		pty_reg[`PCR_PVE_BIT]};
	assign trip = fault_cond_i & en_mask;
	assign any_trip = |trip;
	assign latch_trip = |(trip & pty_reg[5:0]);
	assign tmr_done = (tmr_reg == {`PCR_TMR_W{1'b0}});
	// latch exit waits only on the status bits of the latching cause
	assign sts_clear_ok = &(sts_reg | ~cause_reg);
	assign cl_wr = (reg_wdata_i[`PCR_CL_MSB:`PCR_CL_LSB] > `PCR_CL_MAX) ?
		`PCR_CL_MAX : reg_wdata_i[`PCR_CL_MSB:`PCR_CL_LSB];

	// whole-byte writes: every field of a register changes on one edge
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			cld_reg <= `PCR_CLD_RST;
			thr_reg <= `PCR_THR_RST;
			pty_reg <= `PCR_PTY_RST;
		end else if (reg_wr_i) begin
			case (reg_sel_i)
				`PCR_IDX_CLD: begin
					cld_reg <= {reg_wdata_i[7:4], cl_wr};
				end
				`PCR_IDX_THR: begin
					thr_reg <= reg_wdata_i & `PCR_THR_IMPL_MASK;
				end
				`PCR_IDX_PTY: begin
					pty_reg <= reg_wdata_i;
				end
				default: begin
				end
			endcase
		end
	end

	// status: active-low sticky bits; a present condition beats a clear
	always @* begin
		sts_next = sts_reg & ~trip;
		if (reg_wr_i && reg_sel_i == `PCR_IDX_STS) begin
			sts_next = sts_next | (reg_wdata_i[5:0] & ~trip);
		end
	end

	// read data lags reg_sel_i by one cycle, no read strobe
	always @* begin
		case (reg_sel_i)
			`PCR_IDX_CLD: rdata_next = cld_reg;
			`PCR_IDX_THR: rdata_next = thr_reg & `PCR_THR_IMPL_MASK;
			`PCR_IDX_PTY: rdata_next = pty_reg;
			default: rdata_next = {~temp_warn_i, ~power_good_warn_i,
				sts_reg};
		endcase
	end

	// droop slope in hundredths of V/A/Ohm
	// reserved codes give no droop and raise a flag for software
	always @* begin
		slope_rsv = 1'b0;
		case (cld_reg[`PCR_DROOP_MSB:`PCR_DROOP_LSB])
			3'h0: slope_tab = 8'h00;
			3'h1: slope_tab = 8'h27;
			3'h3: slope_tab = 8'h76;
			3'h4: slope_tab = 8'h9d;
			3'h5: slope_tab = 8'heb;
			default: begin
				slope_tab = 8'h00;
				slope_rsv = 1'b1;
			end
		endcase
	end

	// current limit as percent of rated current
	always @* begin
		case (cld_reg[`PCR_CL_MSB:`PCR_CL_LSB])
			4'h0: cl_tab = 8'h25;
			4'h1: cl_tab = 8'h2f;
			4'h2: cl_tab = 8'h38;
			4'h3: cl_tab = 8'h41;
			4'h4: cl_tab = 8'h4b;
			4'h5: cl_tab = 8'h54;
			4'h6: cl_tab = 8'h5d;
			4'h7: cl_tab = 8'h67;
			4'h8: cl_tab = 8'h70;
			4'h9: cl_tab = 8'h79;
			4'ha: cl_tab = 8'h83;
			default: cl_tab = 8'h8c;
		endcase
	end

	always @* begin
		case (thr_reg[`PCR_OVL_MSB:`PCR_OVL_LSB])
			2'h0: ov_pct = 8'h6e;
			2'h1: ov_pct = 8'h78;
			default: ov_pct = 8'h82;
		endcase
		case (thr_reg[`PCR_UVL_MSB:`PCR_UVL_LSB])
			2'h0: uv_pct = 8'h4b;
			2'h1: uv_pct = 8'h50;
			default: uv_pct = 8'h55;
		endcase
		pg_pct = thr_reg[`PCR_PGL_BIT] ? 8'h5f : 8'h5a;
	end

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
			droop_slope_o <= 8'h00;
			droop_code_reserved_o <= 1'b0;
			current_limit_pct_o <= 8'h00;
			temp_comp_enable_o <= 1'b0;
		end else begin
			reg_rdata_o <= rdata_next;
			droop_slope_o <= slope_tab;
			droop_code_reserved_o <= slope_rsv;
			current_limit_pct_o <= cl_tab;
			temp_comp_enable_o <= cld_reg[`PCR_TCE_BIT];
		end
	end

	// absolute levels track the live setpoint
	pcr_pct_scale #(.MV_W(MV_W)) u_ov (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.setpoint_mv_i(setpoint_mv_i),
		.pct_i(ov_pct),
		.level_mv_o(overvoltage_mv_o)
	);

	pcr_pct_scale #(.MV_W(MV_W)) u_uv (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.setpoint_mv_i(setpoint_mv_i),
		.pct_i(uv_pct),
		.level_mv_o(undervoltage_mv_o)
	);

	pcr_pct_scale #(.MV_W(MV_W)) u_pg (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.setpoint_mv_i(setpoint_mv_i),
		.pct_i(pg_pct),
		.level_mv_o(power_good_low_mv_o)
	);

	// restart policy
	always @* begin
		state_next = state_reg;
		tmr_next = tmr_done ? tmr_reg : tmr_reg - 1'b1;
		cycled_next = cycled_reg;
		cause_next = cause_reg;
		case (state_reg)
			S_OFF: begin
				if (turn_on_i && !any_trip) begin
					state_next = S_RUN;
				end
			end
			S_RUN: begin
				if (any_trip) begin
					tmr_next = TMR_LOAD;
					cycled_next = 1'b0;
					cause_next = trip & pty_reg[5:0];
					state_next = latch_trip ? S_LATCH : S_RETRY;
				end else if (!turn_on_i) begin
					state_next = S_OFF;
				end
			end
			S_RETRY: begin
				if (!turn_on_i) begin
					state_next = S_OFF;
				end else if (tmr_done) begin
					// restart even while the fault holds; it retrips
					state_next = S_RUN;
				end
			end
			S_LATCH: begin
				if (!turn_on_i) begin
					cycled_next = 1'b1;
				end
				// either way out needs the hold-off and a clear condition
				if (tmr_done && !any_trip && turn_on_i &&
					(cycled_reg || sts_clear_ok)) begin
					state_next = S_RUN;
				end
			end
			default: state_next = S_OFF;
		endcase
	end

	// outputs decode state_next so they move with the state
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_reg <= S_OFF;
			tmr_reg <= {`PCR_TMR_W{1'b0}};
			cycled_reg <= 1'b0;
			sts_reg <= `PCR_STS_RST;
			cause_reg <= 6'h00;
			output_enable_o <= 1'b0;
			ramp_request_o <= 1'b0;
			latched_off_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			tmr_reg <= tmr_next;
			cycled_reg <= cycled_next;
			sts_reg <= sts_next;
			cause_reg <= cause_next;
			output_enable_o <= (state_next == S_RUN);
			// every entry into run ramps via tracking and sequencing
			ramp_request_o <= (state_next == S_RUN) &&
				(state_reg != S_RUN);
			latched_off_o <= (state_next == S_LATCH);
		end
	end

endmodule // pcr_protection_config_regs

// >>> pcr_regs_sva.sv
// assertions on the protection configuration register bank
`timescale 1ns/1ps
module pcr_regs_sva (
	input wire clk_i,
	input wire rst_n_i,
	input wire [1:0] reg_sel_i,
	input wire reg_wr_i,
	input wire [7:0] reg_wdata_i,
	input wire [7:0] reg_rdata_o,
	input wire temp_warn_i,
	input wire power_good_warn_i,
	input wire [7:0] droop_slope_o,
	input wire droop_code_reserved_o,
	input wire [7:0] current_limit_pct_o,
	input wire temp_comp_enable_o,
	input wire output_enable_o,
	input wire ramp_request_o,
	input wire latched_off_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	AST_SLOPE_SET: assert property (droop_slope_o inside
		{8'h00, 8'h27, 8'h76, 8'h9d, 8'heb}) else $error("slope off table");
	AST_LIMIT_SAT: assert property (reg_wr_i && reg_sel_i == 2'h0 &&
		reg_wdata_i[3:0] > 4'ha |-> ##2 current_limit_pct_o == 8'h8c)
		else $error("limit not saturated");
	AST_TCE_WR: assert property (reg_wr_i && reg_sel_i == 2'h0 |->
		##2 temp_comp_enable_o == $past(reg_wdata_i[4], 2))
		else $error("tce not taken");
	AST_THR_ZERO: assert property (reg_sel_i == 2'h1 |=>
		reg_rdata_o[7:5] == 3'h0) else $error("thr upper bits set");
	AST_RSV_ZERO: assert property (droop_code_reserved_o |->
		droop_slope_o == 8'h00) else $error("reserved slope nonzero");
	AST_LATCH_OFF: assert property (latched_off_o |->
		!output_enable_o) else $error("on while latched");
	AST_RAMP_ROSE: assert property ($rose(output_enable_o) |->
		ramp_request_o) else $error("start without ramp");
	AST_RAMP_ONE: assert property (ramp_request_o |=>
		!ramp_request_o) else $error("ramp pulse too long");
	AST_WARN_LOW: assert property (reg_sel_i == 2'h3 |=>
		reg_rdata_o[7:6] == ~$past({temp_warn_i, power_good_warn_i}))
		else $error("warning bits not active low");
	cover property (ramp_request_o);
	cover property (latched_off_o);
	cover property (droop_code_reserved_o);
endmodule // pcr_regs_sva
bind pcr_protection_config_regs pcr_regs_sva pcr_regs_sva_inst (.*);

// >>> pcr_host_model.sv
// host model driving the register port of the bank
`timescale 1ns/1ps
module pcr_host_model (
	input wire clk_i,
	output logic [1:0] reg_sel_o,
	output logic reg_wr_o,
	output logic [7:0] reg_wdata_o,
	input wire [7:0] reg_rdata_i
);
	initial begin
		reg_sel_o = 2'h0;
		reg_wr_o = 1'b0;
		reg_wdata_o = 8'h00;
	end
	task automatic wr(input logic [1:0] s, input logic [7:0] d);
		@(negedge clk_i);
		reg_sel_o = s;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(negedge clk_i);
		reg_wr_o = 1'b0;
		// stale data must not be mistaken for a write
		reg_wdata_o = ~d;
	endtask
	task automatic rd(input logic [1:0] s, output logic [7:0] d);
		@(negedge clk_i);
		reg_sel_o = s;
		@(negedge clk_i);
		d = reg_rdata_i;
	endtask
endmodule // pcr_host_model

// >>> pcr_protection_config_regs_tb_top.sv
// testbench for the protection configuration register bank
`timescale 1ns/1ps
module pcr_protection_config_regs_tb_top;
	localparam int RT = 20;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [5:0] flt = 6'h00;
	logic ton = 1'b0;
	logic tw = 1'b0;
	logic pgw = 1'b0;
	logic [15:0] spt = 16'h03e8;
	logic [7:0] rv;
	wire [1:0] sel;
	wire wr;
	wire [7:0] wd, rdat, slope, pct;
	wire rsv, temp_comp_enable, oe, ramp, lat;
	wire [15:0] ovm, uvm, pgm;
	int n_errors = 0;
	int checked = 0;
	int n;
	initial forever #12.5 clk_i = ~clk_i;
	pcr_host_model pcr_host_model_inst (.clk_i(clk_i), .reg_sel_o(sel),
		.reg_wr_o(wr), .reg_wdata_o(wd), .reg_rdata_i(rdat));
	pcr_protection_config_regs #(.RETRY_CYCLES(RT))
		pcr_protection_config_regs_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.reg_sel_i(sel), .reg_wr_i(wr), .reg_wdata_i(wd),
		.reg_rdata_o(rdat), .fault_cond_i(flt), .temp_warn_i(tw),
		.power_good_warn_i(pgw), .turn_on_i(ton), .setpoint_mv_i(spt),
		.droop_slope_o(slope), .droop_code_reserved_o(rsv),
		.current_limit_pct_o(pct), .temp_comp_enable_o(temp_comp_enable),
		.overvoltage_mv_o(ovm), .undervoltage_mv_o(uvm),
		.power_good_low_mv_o(pgm), .output_enable_o(oe),
		.ramp_request_o(ramp), .latched_off_o(lat));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("Error t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(negedge clk_i);
	endtask
	task automatic wait_oe(input logic v, output int c);
		c = 0;
		while (oe !== v && c < 4 * RT) begin
			tick(1);
			c++;
		end
	endtask
	task automatic t_reset;
		logic [7:0] ex [4] = '{8'h1b, 8'h08, 8'h47, 8'hff};
		for (int i = 0; i < 4; i++) begin
			pcr_host_model_inst.rd(i[1:0], rv);
			chk(rv, ex[i]);
		end
		tw = 1'b1;
		pgw = 1'b1;
		pcr_host_model_inst.rd(2'h3, rv);
		chk(rv, 8'h3f);
		tw = 1'b0;
		pgw = 1'b0;
		chk(temp_comp_enable, 1'b1);
		chk(pct, 8'h8c);
		$display("test reset done");
	endtask
	task automatic t_droop;
		logic [7:0] sl [8] = '{8'h00, 8'h27, 8'h00, 8'h76, 8'h9d, 8'heb,
			8'h00, 8'h00};
		for (int i = 0; i < 8; i++) begin
			pcr_host_model_inst.wr(2'h0, {i[2:0], 5'h00});
			tick(2);
			chk(slope, sl[i]);
			chk(rsv, i == 2 || i > 5);
			chk(temp_comp_enable, 1'b0);
		end
		chk(pct, 8'h25);
		$display("test droop done");
	endtask
	task automatic t_limit;
		logic [3:0] cd [5] = '{4'h0, 4'h1, 4'hb, 4'hc, 4'hf};
		logic [7:0] pc [5] = '{8'h25, 8'h2f, 8'h8c, 8'h8c, 8'h8c};
		for (int i = 0; i < 5; i++) begin
			pcr_host_model_inst.wr(2'h0, {4'h1, cd[i]});
			tick(2);
			chk(pct, pc[i]);
		end
		pcr_host_model_inst.rd(2'h0, rv);
		chk(rv, 8'h1b);
		$display("test limit done");
	endtask
	task automatic t_thr;
		logic [15:0] ov [3] = '{16'h044c, 16'h04b0, 16'h0514};
		logic [15:0] uv [3] = '{16'h02ee, 16'h0320, 16'h0352};
		pcr_host_model_inst.wr(2'h1, 8'hff);
		pcr_host_model_inst.rd(2'h1, rv);
		chk(rv, 8'h1f);
		chk(ovm, 16'h0514);
		chk(pgm, 16'h03b6);
		spt = 16'h07d0;
		tick(3);
		chk(ovm, 16'h0a28);
		chk(uvm, 16'h06a4);
		spt = 16'h03e8;
		for (int i = 0; i < 3; i++) begin
			pcr_host_model_inst.wr(2'h1, {4'h0, i[1:0], i[1:0]});
			tick(3);
			chk(ovm, ov[i]);
			chk(uvm, uv[i]);
		end
		chk(pgm, 16'h0384);
		chk(uvm, 16'h0352);
		$display("test thresholds done");
	endtask
	task automatic t_retry;
		ton = 1'b1;
		wait_oe(1'b1, n);
		flt = 6'h08;
		wait_oe(1'b0, n);
		chk(n < 4, 1'b1);
		for (int i = 0; i < 2; i++) begin
			wait_oe(1'b1, n);
			chk(n > RT - 4 && n < RT + 4, 1'b1);
			chk(ramp, 1'b1);
			wait_oe(1'b0, n);
		end
		flt = 6'h00;
		tick(3 * RT);
		chk(oe, 1'b1);
		pcr_host_model_inst.wr(2'h3, 8'hff);
		$display("test retry done");
	endtask
	task automatic t_latch;
		flt = 6'h04;
		wait_oe(1'b0, n);
		chk(lat, 1'b1);
		pcr_host_model_inst.rd(2'h3, rv);
		chk(rv[2], 1'b0);
		flt = 6'h00;
		tick(3 * RT);
		chk(oe, 1'b0);
		ton = 1'b0;
		tick(2);
		ton = 1'b1;
		wait_oe(1'b1, n);
		chk(oe, 1'b1);
		pcr_host_model_inst.wr(2'h2, 8'h4f);
		flt = 6'h08;
		wait_oe(1'b0, n);
		chk(lat, 1'b1);
		flt = 6'h00;
		pcr_host_model_inst.wr(2'h3, 8'hff);
		wait_oe(1'b1, n);
		chk(n > RT - 3 && n < RT + 4, 1'b1);
		$display("test latch done");
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk_i);
		n_errors++;
		report_and_stop;
	end
	initial begin
		tick(20);
		rst_n_i = 1'b1;
		tick(2);
		t_reset;
		t_droop;
		t_limit;
		t_thr;
		t_retry;
		t_latch;
		report_and_stop;
	end
endmodule // pcr_protection_config_regs_tb_top
